//--- spd_master.sv
// serial master with buffer transfer, apb register file and byte sequencer
`timescale 1ns/1ps
// Contract
// (RL1) begin trigger starts transfer with buffers
// (RL2) halt trigger stops, then halted flag rises
// (RL3) pause trigger suspends transfer without ending
// (RL4) continue trigger resumes suspended transfer
// (RL5) halted flag resets 0, set on stop
// (RL6) rx end flag when rx limit reached
// (RL7) both end flag needs rx and tx end
// (RL8) tx end flag when tx limit sent
// (RL9) rx limit caps bytes written to memory
// (RL10) tx limit caps bytes fetched from memory
// (RL11) done counts report bytes per direction
// (RL12) filler byte sent after tx buffer exhausted
// (RL13) pin route registers for data out/in
// (RL14) rate register selects serial clock rate
// (RL15) stop forces missing rx/tx end flags
// (RL16) excess received bytes are discarded
// (RL17) pointers and limits latched at start
// (RL18) shortcut: both end restarts transfer
// (RL19) software clears flags by writing zero
// (RL20) suspended: clock idle, positions kept
module spd_master
   import spd_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [DW-1:0] pwdata,
   output logic [DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // buffer memory port
   output logic mem_req,
   output logic mem_we,
   output logic [DW-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   // serial pins
   output logic sck_out,
   output logic sck_oe,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   // pin routing to the pad mux
   output logic [DW-1:0] sck_route,
   output logic [DW-1:0] mosi_route,
   output logic [DW-1:0] miso_route
);
   spd_state_e st_reg;
   logic [DW-1:0] prdata_reg;
   logic [ENABLE_W-1:0] enable_reg;
   logic [FMT_W-1:0] fmt_reg, fmt_w;
   logic [RATE_W-1:0] rate_reg, rate_w;
   logic [7:0] filler_reg;
   logic [DW-1:0] rx_ptr_reg, tx_ptr_reg, rx_ptr_w, tx_ptr_w;
   logic [CNT_W-1:0] rx_max_reg, tx_max_reg, rx_max_w, tx_max_w;
   logic [CNT_W-1:0] rx_cnt_reg, tx_cnt_reg;
   logic [DW-1:0] sck_pin_reg, mosi_pin_reg, miso_pin_reg;
   logic [1:0] rx_list_reg, tx_list_reg;
   logic short_reg;
   logic [IEN_W-1:0] ien_reg;
   logic ev_halted, ev_rxend, ev_bothend, ev_txend, ev_begun;
   logic rx_done_reg, tx_done_reg, end_sent_reg;
   logic halt_pend_reg, paused_reg;
   logic [RATE_W-1:0] div_cnt_reg;
   logic [HALF_W-1:0] half_reg;
   logic sck_reg;
   logic [7:0] tx_sh_reg, rx_sh_reg;
   logic miso_s1, miso_s2;
   logic wr_acc, rd_setup, hit;
   logic begin_wr, halt_wr, pause_wr, cont_wr;
   logic enabled, rx_more, tx_more, half_end, sample_now, shift_now;
   logic stop_now, start_go, set_rxend, set_txend, set_bothend;

   function automatic logic [7:0] spd_rev(input logic [7:0] b);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 8; i++) begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   // apb decode and task strobes
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite && ce;
   assign rd_setup = psel && !penable && ce;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_reg;
   assign begin_wr = wr_acc && paddr == OFF_BEGIN && pwdata[0];
   assign halt_wr = wr_acc && paddr == OFF_HALT && pwdata[0];
   assign pause_wr = wr_acc && paddr == OFF_PAUSE && pwdata[0];
   assign cont_wr = wr_acc && paddr == OFF_CONT && pwdata[0];

   always_comb begin
      hit = 1'b1;
      if (paddr == OFF_BEGIN || paddr == OFF_HALT || paddr == OFF_PAUSE) begin
         hit = 1'b1;
      end else if (paddr == OFF_CONT || paddr == OFF_HALTED || paddr == OFF_RXEND) begin
         hit = 1'b1;
      end else if (paddr == OFF_BOTHEND || paddr == OFF_TXEND || paddr == OFF_BEGUN) begin
         hit = 1'b1;
      end else if (paddr == OFF_LINKS || paddr == OFF_IENSET || paddr == OFF_IENCLR) begin
         hit = 1'b1;
      end else if (paddr == OFF_ENABLE || paddr == OFF_SCKPIN || paddr == OFF_DOPIN) begin
         hit = 1'b1;
      end else if (paddr == OFF_DIPIN || paddr == OFF_RATE || paddr == OFF_RXPTR) begin
         hit = 1'b1;
      end else if (paddr == OFF_RXMAX || paddr == OFF_RXAMT || paddr == OFF_RXLIST) begin
         hit = 1'b1;
      end else if (paddr == OFF_TXPTR || paddr == OFF_TXMAX || paddr == OFF_TXAMT) begin
         hit = 1'b1;
      end else if (paddr == OFF_TXLIST || paddr == OFF_FORMAT || paddr == OFF_FILLER) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= RST_ZERO;
      end else if (rd_setup) begin
         prdata_reg <= RST_ZERO;
         if (paddr == OFF_HALTED) begin
            prdata_reg[0] <= ev_halted; // RL5
         end else if (paddr == OFF_RXEND) begin
            prdata_reg[0] <= ev_rxend;
         end else if (paddr == OFF_BOTHEND) begin
            prdata_reg[0] <= ev_bothend;
         end else if (paddr == OFF_TXEND) begin
            prdata_reg[0] <= ev_txend;
         end else if (paddr == OFF_BEGUN) begin
            prdata_reg[0] <= ev_begun;
         end else if (paddr == OFF_LINKS) begin
            prdata_reg[0] <= short_reg;
         end else if (paddr == OFF_IENSET || paddr == OFF_IENCLR) begin
            prdata_reg[IEN_W-1:0] <= ien_reg;
         end else if (paddr == OFF_ENABLE) begin
            prdata_reg[ENABLE_W-1:0] <= enable_reg;
         end else if (paddr == OFF_SCKPIN) begin
            prdata_reg <= sck_pin_reg;
         end else if (paddr == OFF_DOPIN) begin
            prdata_reg <= mosi_pin_reg;
         end else if (paddr == OFF_DIPIN) begin
            prdata_reg <= miso_pin_reg;
         end else if (paddr == OFF_RATE) begin
            prdata_reg[RATE_W-1:0] <= rate_reg;
         end else if (paddr == OFF_RXPTR) begin
            prdata_reg <= rx_ptr_reg;
         end else if (paddr == OFF_RXMAX) begin
            prdata_reg[CNT_W-1:0] <= rx_max_reg;
         end else if (paddr == OFF_RXAMT) begin
            prdata_reg[CNT_W-1:0] <= rx_cnt_reg; // RL11
         end else if (paddr == OFF_RXLIST) begin
            prdata_reg[1:0] <= rx_list_reg;
         end else if (paddr == OFF_TXPTR) begin
            prdata_reg <= tx_ptr_reg;
         end else if (paddr == OFF_TXMAX) begin
            prdata_reg[CNT_W-1:0] <= tx_max_reg;
         end else if (paddr == OFF_TXAMT) begin
            prdata_reg[CNT_W-1:0] <= tx_cnt_reg; // RL11
         end else if (paddr == OFF_TXLIST) begin
            prdata_reg[1:0] <= tx_list_reg;
         end else if (paddr == OFF_FORMAT) begin
            prdata_reg[FMT_W-1:0] <= fmt_reg;
         end else if (paddr == OFF_FILLER) begin
            prdata_reg[7:0] <= filler_reg;
         end
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= '0;
         short_reg <= 1'b0;
         ien_reg <= '0;
         sck_pin_reg <= RST_ZERO;
         mosi_pin_reg <= RST_ZERO;
         miso_pin_reg <= RST_ZERO;
         rate_reg <= '0;
         rx_ptr_reg <= RST_ZERO;
         tx_ptr_reg <= RST_ZERO;
         rx_max_reg <= '0;
         tx_max_reg <= '0;
         rx_list_reg <= '0;
         tx_list_reg <= '0;
         fmt_reg <= '0;
         filler_reg <= '0;
      end else if (wr_acc) begin
         if (paddr == OFF_LINKS) begin
            short_reg <= pwdata[0];
         end else if (paddr == OFF_IENSET) begin
            ien_reg <= ien_reg | pwdata[IEN_W-1:0];
         end else if (paddr == OFF_IENCLR) begin
            ien_reg <= ien_reg & ~pwdata[IEN_W-1:0];
         end else if (paddr == OFF_ENABLE) begin
            enable_reg <= pwdata[ENABLE_W-1:0];
         end else if (paddr == OFF_SCKPIN) begin
            sck_pin_reg <= pwdata;
         end else if (paddr == OFF_DOPIN) begin
            mosi_pin_reg <= pwdata; // RL13
         end else if (paddr == OFF_DIPIN) begin
            miso_pin_reg <= pwdata; // RL13
         end else if (paddr == OFF_RATE) begin
            rate_reg <= pwdata[RATE_W-1:0]; // RL14
         end else if (paddr == OFF_RXPTR) begin
            rx_ptr_reg <= pwdata;
         end else if (paddr == OFF_RXMAX) begin
            rx_max_reg <= pwdata[CNT_W-1:0]; // RL9
         end else if (paddr == OFF_RXLIST) begin
            rx_list_reg <= pwdata[1:0];
         end else if (paddr == OFF_TXPTR) begin
            tx_ptr_reg <= pwdata;
         end else if (paddr == OFF_TXMAX) begin
            tx_max_reg <= pwdata[CNT_W-1:0]; // RL10
         end else if (paddr == OFF_TXLIST) begin
            tx_list_reg <= pwdata[1:0];
         end else if (paddr == OFF_FORMAT) begin
            fmt_reg <= pwdata[FMT_W-1:0];
         end else if (paddr == OFF_FILLER) begin
            filler_reg <= pwdata[7:0];
         end
      end
   end

   // sequencer conditions
   assign enabled = enable_reg == ENABLE_ON;
   assign rx_more = rx_cnt_reg < rx_max_w; // RL9
   assign tx_more = tx_cnt_reg < tx_max_w; // RL10
   assign half_end = div_cnt_reg == rate_w; // RL14
   assign sample_now = half_end && (fmt_w[FMT_CPHA] ? half_reg[0] : !half_reg[0]);
   assign shift_now = half_end && (fmt_w[FMT_CPHA] ? (!half_reg[0] && half_reg != FIRST_HALF)
                                                   : (half_reg[0] && half_reg != LAST_HALF));
   assign stop_now = halt_pend_reg && (st_reg == ST_IDLE || (st_reg == ST_FETCH && !mem_req));
   assign set_rxend = !rx_done_reg && ((st_reg != ST_IDLE && !rx_more) ||
                                       (stop_now && st_reg != ST_IDLE)); // RL6 RL15
   assign set_txend = !tx_done_reg && ((st_reg != ST_IDLE && !tx_more) ||
                                       (stop_now && st_reg != ST_IDLE)); // RL8 RL15
   assign set_bothend = rx_done_reg && tx_done_reg && !end_sent_reg; // RL7
   assign start_go = enabled && !halt_pend_reg && st_reg == ST_IDLE &&
                     (begin_wr || (short_reg && set_bothend)); // RL1 RL18

   // miso crosses in through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         miso_s1 <= 1'b0;
         miso_s2 <= 1'b0;
      end else if (ce) begin
         miso_s1 <= miso_in;
         miso_s2 <= miso_s1;
      end
   end

   // halt and pause requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_pend_reg <= 1'b0;
         paused_reg <= 1'b0;
      end else if (ce) begin
         if (halt_wr) begin
            halt_pend_reg <= 1'b1; // RL2
         end else if (stop_now) begin
            halt_pend_reg <= 1'b0;
         end
         if (start_go || cont_wr) begin
            paused_reg <= 1'b0; // RL4
         end else if (pause_wr && st_reg != ST_IDLE) begin
            paused_reg <= 1'b1; // RL3
         end
      end
   end

   // byte sequencer, memory port and shifter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= ST_IDLE;
         rx_ptr_w <= RST_ZERO;
         tx_ptr_w <= RST_ZERO;
         rx_max_w <= '0;
         tx_max_w <= '0;
         rate_w <= '0;
         fmt_w <= '0;
         rx_cnt_reg <= '0;
         tx_cnt_reg <= '0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= RST_ZERO;
         mem_wdata <= '0;
         div_cnt_reg <= '0;
         half_reg <= '0;
         sck_reg <= 1'b0;
         tx_sh_reg <= '0;
         rx_sh_reg <= '0;
      end else if (ce) begin
         case (st_reg)
            ST_IDLE: begin
               sck_reg <= fmt_reg[FMT_CPOL];
               if (start_go) begin
                  rx_ptr_w <= rx_ptr_reg; // RL17
                  tx_ptr_w <= tx_ptr_reg;
                  rx_max_w <= rx_max_reg;
                  tx_max_w <= tx_max_reg;
                  rate_w <= rate_reg;
                  fmt_w <= fmt_reg;
                  rx_cnt_reg <= '0;
                  tx_cnt_reg <= '0;
                  st_reg <= ST_FETCH; // RL1
               end
            end
            ST_FETCH: begin
               div_cnt_reg <= '0;
               half_reg <= '0;
               if (mem_req) begin
                  if (mem_ack) begin
                     mem_req <= 1'b0;
                     tx_sh_reg <= fmt_w[FMT_LSB_FIRST] ? spd_rev(mem_rdata) : mem_rdata;
                     st_reg <= ST_SHIFT;
                  end
               end else if (stop_now) begin
                  st_reg <= ST_IDLE; // RL2
               end else if (paused_reg) begin
                  st_reg <= ST_FETCH; // RL20
               end else if (!tx_more && !rx_more) begin
                  st_reg <= ST_IDLE;
               end else if (tx_more) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= tx_ptr_w + {{(DW-CNT_W){1'b0}}, tx_cnt_reg};
               end else begin
                  tx_sh_reg <= fmt_w[FMT_LSB_FIRST] ? spd_rev(filler_reg) : filler_reg; // RL12
                  st_reg <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (half_end) begin
                  div_cnt_reg <= '0;
                  sck_reg <= !sck_reg;
                  half_reg <= half_reg + 1'b1;
                  if (sample_now) begin
                     rx_sh_reg <= {rx_sh_reg[6:0], miso_s2};
                  end
                  if (shift_now) begin
                     tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                  end
                  if (half_reg == LAST_HALF) begin
                     st_reg <= ST_STORE;
                  end
               end else begin
                  div_cnt_reg <= div_cnt_reg + 1'b1;
               end
            end
            ST_STORE: begin
               if (mem_req) begin
                  if (mem_ack) begin
                     mem_req <= 1'b0;
                     rx_cnt_reg <= rx_cnt_reg + 1'b1;
                     tx_cnt_reg <= tx_cnt_reg + {{(CNT_W-1){1'b0}}, tx_more};
                     st_reg <= ST_FETCH;
                  end
               end else if (rx_more) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= rx_ptr_w + {{(DW-CNT_W){1'b0}}, rx_cnt_reg};
                  mem_wdata <= fmt_w[FMT_LSB_FIRST] ? spd_rev(rx_sh_reg) : rx_sh_reg;
               end else begin
                  tx_cnt_reg <= tx_cnt_reg + {{(CNT_W-1){1'b0}}, tx_more}; // RL16
                  st_reg <= ST_FETCH;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // per-transfer end tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_done_reg <= 1'b0;
         tx_done_reg <= 1'b0;
         end_sent_reg <= 1'b0;
      end else if (ce) begin
         if (start_go) begin
            rx_done_reg <= 1'b0;
            tx_done_reg <= 1'b0;
            end_sent_reg <= 1'b0;
         end else begin
            rx_done_reg <= rx_done_reg || set_rxend;
            tx_done_reg <= tx_done_reg || set_txend;
            end_sent_reg <= end_sent_reg || set_bothend;
         end
      end
   end

   // event flags: hardware set wins over a software write of zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_halted <= 1'b0;
         ev_rxend <= 1'b0;
         ev_bothend <= 1'b0;
         ev_txend <= 1'b0;
         ev_begun <= 1'b0;
      end else if (ce) begin
         if (stop_now) begin
            ev_halted <= 1'b1; // RL5
         end else if (wr_acc && paddr == OFF_HALTED) begin
            ev_halted <= pwdata[0]; // RL19
         end
         if (set_rxend) begin
            ev_rxend <= 1'b1; // RL6
         end else if (wr_acc && paddr == OFF_RXEND) begin
            ev_rxend <= pwdata[0];
         end
         if (set_bothend) begin
            ev_bothend <= 1'b1; // RL7
         end else if (wr_acc && paddr == OFF_BOTHEND) begin
            ev_bothend <= pwdata[0];
         end
         if (set_txend) begin
            ev_txend <= 1'b1; // RL8
         end else if (wr_acc && paddr == OFF_TXEND) begin
            ev_txend <= pwdata[0];
         end
         if (start_go) begin
            ev_begun <= 1'b1; // RL17
         end else if (wr_acc && paddr == OFF_BEGUN) begin
            ev_begun <= pwdata[0];
         end
      end
   end

   // pins
   assign sck_out = sck_reg;
   assign mosi_out = tx_sh_reg[7];
   assign sck_oe = enabled;
   assign mosi_oe = enabled;
   assign sck_route = sck_pin_reg;
   assign mosi_route = mosi_pin_reg;
   assign miso_route = miso_pin_reg;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_start_begins: assert property (ce && start_go |=> st_reg == ST_FETCH && ev_begun) // RL1
      else $error("start did not begin a transfer");
   a_halt_flags: assert property (ce && st_reg == ST_FETCH && stop_now // RL2
         |=> st_reg == ST_IDLE && ev_halted && rx_done_reg && tx_done_reg)
      else $error("halt did not stop with flags");
   a_pause_holds: assert property (ce && paused_reg && st_reg == ST_FETCH && !mem_req // RL3
         && !halt_pend_reg && !cont_wr |=> st_reg == ST_FETCH && sck_out == fmt_w[FMT_CPOL])
      else $error("paused transfer moved");
   a_resume_clears: assert property (ce && cont_wr |=> !paused_reg) // RL4
      else $error("continue did not clear pause");
   a_rx_end: assert property ($rose(rx_done_reg) |-> ev_rxend) // RL6
      else $error("rx end flag missing");
   // a shortcut restart clears the done bits in the edge that raises the flag
   a_both_end: assert property ($rose(ev_bothend) && !$past(wr_acc) // RL7
         |-> $past(rx_done_reg && tx_done_reg))
      else $error("both end raised early");
   a_tx_end: assert property (ce && st_reg == ST_FETCH && !tx_more && !tx_done_reg // RL8
         |=> ev_txend)
      else $error("tx end flag missing");
   a_rx_discard: assert property (mem_req && mem_we |-> rx_cnt_reg < rx_max_w) // RL16
      else $error("write past rx limit");
   a_filler_sent: assert property (ce && st_reg == ST_FETCH && !mem_req && !stop_now // RL12
         && !paused_reg && !tx_more && rx_more && !fmt_w[FMT_LSB_FIRST]
         |=> tx_sh_reg == filler_reg)
      else $error("filler byte not loaded");
   a_limit_latched: assert property (st_reg != ST_IDLE ##1 st_reg != ST_IDLE // RL17
         |-> $stable(rx_max_w) && $stable(tx_max_w))
      else $error("working limit changed mid transfer");
   c_start: cover property (ce && start_go);
   c_pause: cover property (paused_reg && st_reg == ST_FETCH);
   c_filler: cover property (st_reg == ST_SHIFT && !tx_more);
   c_restart: cover property (short_reg && set_bothend && start_go);
endmodule // spd_master

//--- spd_pkg.sv
// constants for the serial master control block
package spd_pkg;
   localparam int DW = 32;
   localparam int CNT_W = 16;
   localparam int RATE_W = 4;
   localparam int HALF_W = 4;
   // register byte offsets
   localparam logic [11:0] OFF_BEGIN = 12'h010;
   localparam logic [11:0] OFF_HALT = 12'h014;
   localparam logic [11:0] OFF_PAUSE = 12'h01C;
   localparam logic [11:0] OFF_CONT = 12'h020;
   localparam logic [11:0] OFF_HALTED = 12'h104;
   localparam logic [11:0] OFF_RXEND = 12'h110;
   localparam logic [11:0] OFF_BOTHEND = 12'h118;
   localparam logic [11:0] OFF_TXEND = 12'h120;
   localparam logic [11:0] OFF_BEGUN = 12'h14C;
   localparam logic [11:0] OFF_LINKS = 12'h200;
   localparam logic [11:0] OFF_IENSET = 12'h304;
   localparam logic [11:0] OFF_IENCLR = 12'h308;
   localparam logic [11:0] OFF_ENABLE = 12'h500;
   localparam logic [11:0] OFF_SCKPIN = 12'h508;
   localparam logic [11:0] OFF_DOPIN = 12'h50C;
   localparam logic [11:0] OFF_DIPIN = 12'h510;
   localparam logic [11:0] OFF_RATE = 12'h524;
   localparam logic [11:0] OFF_RXPTR = 12'h534;
   localparam logic [11:0] OFF_RXMAX = 12'h538;
   localparam logic [11:0] OFF_RXAMT = 12'h53C;
   localparam logic [11:0] OFF_RXLIST = 12'h540;
   localparam logic [11:0] OFF_TXPTR = 12'h544;
   localparam logic [11:0] OFF_TXMAX = 12'h548;
   localparam logic [11:0] OFF_TXAMT = 12'h54C;
   localparam logic [11:0] OFF_TXLIST = 12'h550;
   localparam logic [11:0] OFF_FORMAT = 12'h554;
   localparam logic [11:0] OFF_FILLER = 12'h5C0;
   // field positions and values
   localparam int ENABLE_W = 4;
   localparam logic [ENABLE_W-1:0] ENABLE_ON = 4'h7;
   localparam int FMT_LSB_FIRST = 0;
   localparam int FMT_CPHA = 1;
   localparam int FMT_CPOL = 2;
   localparam int FMT_W = 3;
   localparam int IEN_W = 5;
   localparam logic [DW-1:0] RST_ZERO = 32'h00000000;
   localparam logic [HALF_W-1:0] LAST_HALF = 4'hF;
   localparam logic [HALF_W-1:0] FIRST_HALF = 4'h0;
   // sequencer states, gray along idle-fetch-shift-store
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_SHIFT = 2'b11,
      ST_STORE = 2'b10
   } spd_state_e;
endpackage

//--- spd_far_model.sv
// far side: byte memory with stall option and one mode 0 serial slave
`timescale 1ns/1ps
module spd_far_model (
   // clock and stall select
   input wire logic pclk,
   input wire logic slow,
   // memory port
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata = 8'h00,
   output logic mem_ack = 1'b0,
   // serial pins
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic [7:0] last_byte = 8'h00
);
   logic [7:0] mem [256];
   logic [7:0] sr = 8'h5A;
   logic [7:0] rx_sr = 8'h00;
   logic [2:0] nb = 3'h0;
   logic [2:0] wt = 3'h0;
   initial foreach (mem[i]) mem[i] = 8'(i);
   assign miso = sr[7];
   always @(posedge sck) begin
      rx_sr = {rx_sr[6:0], mosi};
      nb = nb + 3'h1;
      if (nb == 3'h0) last_byte = rx_sr;
   end
   // between bytes the line shows the first bit of a freshly loaded 5A, not the last data bit
   always @(negedge sck) sr = (nb == 3'h0) ? 8'h5A : {sr[6:0], ~sr[7]};
   always @(posedge pclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         wt <= wt + 3'h1;
         if (wt >= (slow ? 3'h4 : 3'h0)) begin
            mem_ack <= 1'b1;
            wt <= 3'h0;
            mem_rdata <= mem[mem_addr[7:0]];
            if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
         end
      end
   end
endmodule // spd_far_model

//--- spd_master_test.sv
// self-checking bench for the serial master control block
`timescale 1ns/1ps
module spd_master_test
   import spd_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [DW-1:0] pwdata = 32'h00000000;
   logic [DW-1:0] prdata, mem_addr, sck_route, mosi_route, miso_route, q, q2;
   logic pready, pslverr, mem_req, mem_we, mem_ack, sck_out, sck_oe, mosi_out, mosi_oe, miso;
   logic [7:0] mem_wdata, mem_rdata, last_byte;
   logic slverr;
   logic [11:0] evs [5] = '{OFF_HALTED, OFF_RXEND, OFF_BOTHEND, OFF_TXEND, OFF_BEGUN};
   int n_errors = 0;
   int total_checks = 0;
   spd_master DUT (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_ack, .sck_out, .sck_oe, .mosi_out, .mosi_oe, .miso_in(miso), .sck_route,
      .mosi_route, .miso_route);
   spd_far_model far (.pclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
      .mem_ack, .sck(sck_out), .mosi(mosi_out), .miso, .last_byte);
   initial forever #50 pclk = ~pclk;
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [DW-1:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [DW-1:0] exp);
      bus(1'b0, a, RST_ZERO);
      chk(q, exp);
   endtask
   task automatic wait_flag(input logic [11:0] a);
      for (int i = 0; i < 1000; i++) begin
         bus(1'b0, a, RST_ZERO);
         if (q[0] === 1'b1) break;
      end
   endtask
   task automatic run(input logic [DW-1:0] rp, rm, tp, tm);
      foreach (evs[i]) bus(1'b1, evs[i], RST_ZERO);
      bus(1'b1, OFF_RXPTR, rp);
      bus(1'b1, OFF_RXMAX, rm);
      bus(1'b1, OFF_TXPTR, tp);
      bus(1'b1, OFF_TXMAX, tm);
      bus(1'b1, OFF_BEGIN, 32'h1);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      foreach (evs[i]) rchk(evs[i], RST_ZERO);
      rchk(12'h7F0, RST_ZERO);
      chk({31'h0, slverr}, 32'h1);
      chk({30'h0, sck_oe, mosi_oe}, RST_ZERO);
      bus(1'b1, OFF_ENABLE, 32'h7);
      bus(1'b1, OFF_IENSET, 32'h1F);
      bus(1'b1, OFF_IENCLR, 32'h3);
      rchk(OFF_IENSET, 32'h1C);
      bus(1'b1, OFF_RATE, 32'h3);
      rchk(OFF_RATE, 32'h3);
      chk({31'h0, slverr}, RST_ZERO);
      bus(1'b1, OFF_FILLER, 32'hC3);
      bus(1'b1, OFF_SCKPIN, 32'h14);
      bus(1'b1, OFF_DOPIN, 32'h15);
      bus(1'b1, OFF_DIPIN, 32'h16);
      @(posedge pclk);
      chk(sck_route, 32'h14);
      chk(mosi_route, 32'h15);
      chk(miso_route, 32'h16);
      chk({30'h0, sck_oe, mosi_oe}, 32'h3);
      run(32'h40, 32'h3, 32'h10, 32'h2);
      bus(1'b1, OFF_RXMAX, 32'h1);
      wait_flag(OFF_BOTHEND);
      rchk(OFF_RXEND, 32'h1);
      rchk(OFF_TXEND, 32'h1);
      rchk(OFF_RXAMT, 32'h3);
      rchk(OFF_TXAMT, 32'h2);
      for (int i = 64; i < 67; i++) chk({24'h0, far.mem[i]}, 32'h5A);
      chk({24'h0, far.mem[67]}, 32'h43);
      chk({24'h0, last_byte}, 32'hC3);
      slow <= 1'b1;
      run(32'h80, 32'h1, 32'h20, 32'h4);
      wait_flag(OFF_BOTHEND);
      rchk(OFF_RXAMT, 32'h1);
      chk({24'h0, far.mem[129]}, 32'h81);
      chk({24'h0, last_byte}, 32'h23);
      run(32'h90, 32'h6, 32'h30, 32'h6);
      bus(1'b1, OFF_PAUSE, 32'h1);
      repeat (200) @(posedge pclk);
      bus(1'b0, OFF_TXAMT, RST_ZERO);
      q2 = q;
      repeat (300) @(posedge pclk);
      rchk(OFF_TXAMT, q2);
      chk({31'h0, sck_out}, RST_ZERO);
      rchk(OFF_BOTHEND, RST_ZERO);
      bus(1'b1, OFF_CONT, 32'h1);
      wait_flag(OFF_BOTHEND);
      rchk(OFF_TXAMT, 32'h6);
      run(32'hA0, 32'h8, 32'h40, 32'h8);
      repeat (150) @(posedge pclk);
      bus(1'b1, OFF_HALT, 32'h1);
      wait_flag(OFF_HALTED);
      rchk(OFF_HALTED, 32'h1);
      rchk(OFF_RXEND, 32'h1);
      rchk(OFF_TXEND, 32'h1);
      bus(1'b0, OFF_RXAMT, RST_ZERO);
      chk({31'h0, q < 32'h8}, 32'h1);
      // lsb-first byte, then the shortcut restarts the same transfer once
      bus(1'b1, OFF_FORMAT, 32'h1);
      bus(1'b1, OFF_LINKS, 32'h1);
      run(32'hB0, 32'h1, 32'h50, 32'h1);
      bus(1'b1, OFF_BEGUN, RST_ZERO);
      wait_flag(OFF_BEGUN);
      bus(1'b1, OFF_LINKS, RST_ZERO);
      rchk(OFF_BEGUN, 32'h1);
      bus(1'b1, OFF_BOTHEND, RST_ZERO);
      wait_flag(OFF_BOTHEND);
      rchk(OFF_BOTHEND, 32'h1);
      chk({24'h0, last_byte}, 32'h0A);
      wrap_up;
   end
   initial begin
      #5000000;
      n_errors++;
      wrap_up;
   end
endmodule // spd_master_test
